// ### rtl/pmio_ports.v
// Sixteen output cells, twenty input cells and ports A-D with their processor register space.
// Notes on behaviour
// - Group A cells: three own terms, borrow six.
// - Group B cells 0-3: four own, borrow five.
// - Group B cells 4-7: four own, borrow six.
// - A lent term leaves its owner; no sharing.
// - All sixteen cell flops processor writable and readable.
// - Processor load beats preset, clear and clock.
// - Load on strobe trailing edge or level.
// - Per-group write mask, reset zero, one blocks.
// - Pin enable is enable term OR direction.
// - Logic output without enable term drives always.
// - Otherwise direction bit alone drives the pin.
// - Twenty input cells: A, B, four on C.
// - Input cell: latch, register or pass; readable.
// - Input clock: ALE or term per nibble.
// - Ports A-C eight bits, D three; independent.
// - Pin mux: data-out, address, cell, selects.
// - Readback presents one source at a time.
// - Logic, input cell and pin source modes fixed; direction and address-out modes run-time registers.
// - Processor mode: data-out drives, pin readable.
// - Ports C and D lack control registers.
// - Direction one is output; default input.
// - Control one selects address-out mode.
// - Configuration registers reset to zero.
`timescale 1ns/1ps
`include "pmio_consts.vh"
module pmio_ports (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        ioSel,
    input  wire [7:0]  busAddr,
    input  wire [7:0]  busWrData,
    input  wire        busWrStb,
    input  wire        busRdStb,
    input  wire        busAle,
    output reg  [7:0]  busRdData,
    input  wire [55:0] ptTerms,
    input  wire [15:0] cellPreset,
    input  wire [15:0] cellClear,
    input  wire [15:0] cellClkPt,
    input  wire [26:0] ptOe,
    input  wire [4:0]  ptInEn,
    input  wire [1:0]  ecsTerm,
    input  wire        cfgLevelLoad,
    input  wire [31:0] cfgBorrow,
    input  wire [15:0] cfgPol,
    input  wire [15:0] cfgCombo,
    input  wire [15:0] cfgClkPin,
    input  wire [26:0] cfgPinPld,
    input  wire [7:0]  cfgBCellSel,
    input  wire [26:0] cfgOeDef,
    input  wire [39:0] cfgInMode,
    input  wire [4:0]  cfgInAle,
    input  wire [7:0]  paIn,
    input  wire [7:0]  pbIn,
    input  wire [7:0]  pcIn,
    input  wire [2:0]  pdIn,
    output wire [7:0]  paOut,
    output wire [7:0]  paOe,
    output wire [7:0]  pbOut,
    output wire [7:0]  pbOe,
    output wire [7:0]  pcOut,
    output wire [7:0]  pcOe,
    output wire [2:0]  pdOut,
    output wire [2:0]  pdOe,
    output reg  [15:0] cellOut,
    output reg  [19:0] inCellBus
);
    reg  [26:0] pinS1_r;
    reg  [26:0] pinS2_r;
    reg  [26:0] dout_r;
    reg  [26:0] dir_r;
    reg  [15:0] ctl_r;
    reg  [7:0]  maskA_r;
    reg  [7:0]  maskB_r;
    reg  [15:0] cellQ_r;
    reg  [15:0] ptClkPrev_r;
    reg         clkPinPrev_r;
    reg  [4:0]  inEnPrev_r;
    reg  [7:0]  addrLat_r;
    reg         wrStb_r;
    reg         wSel_r;
    reg  [7:0]  wAddr_r;
    reg  [7:0]  wData_r;
    reg  [26:0] pinOut_r;
    reg  [26:0] pinOe_r;
    reg  [7:0]  rdMux;
    wire [26:0] pinRaw;
    wire [31:0] pinPad;
    wire [31:0] doutPad;
    wire [31:0] dirPad;
    wire [23:0] inPad;
    wire [15:0] cellVal;
    wire [15:0] cellSum;
    wire [15:0] lent;
    wire [26:0] pldSrc;
    wire [26:0] muxOut;
    wire [26:0] oeNxt;
    wire [19:0] inCellPin;
    wire [4:0]  inEn;
    wire        wrTrail;
    wire        regWr;
    wire        cellWrA;
    wire        cellWrB;
    wire        clkPinRise;
    wire [7:0]  cellData;

    assign pinRaw  = {pdIn, pcIn, pbIn, paIn};
    assign pinPad  = {5'h00, pinS2_r};
    assign doutPad = {5'h00, dout_r};
    assign dirPad  = {5'h00, dir_r};
    assign inPad   = {4'h0, inCellBus};
    assign {pdOut, pcOut, pbOut, paOut} = pinOut_r;
    assign {pdOe, pcOe, pbOe, paOe}     = pinOe_r;

    // Edge mode uses the address and data held from the last strobe cycle, because the
    // bus may already have moved on when the trailing edge is seen.
    assign wrTrail  = wrStb_r & ~busWrStb & wSel_r;
    assign regWr    = wrTrail;
    assign cellWrA  = cfgLevelLoad ? (busWrStb & ioSel & (busAddr == `PMIO_OFS_CELL_A))
                                   : (wrTrail & (wAddr_r == `PMIO_OFS_CELL_A));
    assign cellWrB  = cfgLevelLoad ? (busWrStb & ioSel & (busAddr == `PMIO_OFS_CELL_B))
                                   : (wrTrail & (wAddr_r == `PMIO_OFS_CELL_B));
    assign cellData = cfgLevelLoad ? busWrData : wData_r;
    assign clkPinRise = pinS2_r[`PMIO_PIN_CLKIN] & ~clkPinPrev_r;

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_cell
            localparam GB  = (i >= 8) ? 8 : 0;
            localparam N1  = GB + ((i - GB + 1) % 8);
            localparam N2  = GB + ((i - GB + 2) % 8);
            localparam P1  = GB + ((i - GB + 7) % 8);
            localparam P2  = GB + ((i - GB + 6) % 8);
            localparam NAT = (i < 8) ? `PMIO_NAT_A : `PMIO_NAT_B;
            localparam BAS = (i < 8) ? i * 3 : 24 + (i - 8) * 4;
            localparam B1  = (N1 < 8) ? N1 * 3 : 24 + (N1 - 8) * 4;
            localparam B2  = (N2 < 8) ? N2 * 3 : 24 + (N2 - 8) * 4;
            localparam [7:0] CAP = (i < 8) ? `PMIO_CAP_A :
                                   (i < 12) ? `PMIO_CAP_B_LO : `PMIO_CAP_B_HI;
            wire [NAT-1:0] own;
            wire [NAT-1:0] t1;
            wire [NAT-1:0] t2;
            wire           take2;
            wire [7:0]     bor;
            wire           sum;
            assign own = ptTerms[BAS +: NAT];
            assign t1  = ptTerms[B1 +: NAT];
            assign t2  = ptTerms[B2 +: NAT];
            // A neighbour one step away has first claim, so a term never serves two cells.
            assign lent[i] = cfgBorrow[2*P1] | (cfgBorrow[2*P2+1] & ~cfgBorrow[2*P1]);
            assign take2   = cfgBorrow[2*i+1] & ~cfgBorrow[2*N1];
            if (i < 8) begin : g_a
                assign bor = {2'h0, take2 ? t2 : 3'h0, cfgBorrow[2*i] ? t1 : 3'h0} & CAP;
            end else begin : g_b
                assign bor = {take2 ? t2 : 4'h0, cfgBorrow[2*i] ? t1 : 4'h0} & CAP;
            end
            assign sum = ((|own) & ~lent[i]) | (|bor);
            // Registered and combinational paths both take the polarity-adjusted sum.
            assign cellSum[i] = sum ^ cfgPol[i];
            assign cellVal[i] = cfgCombo[i] ? cellSum[i] : cellQ_r[i];
        end
        for (i = 0; i < 27; i = i + 1) begin : g_pin
            if (i < 8) begin : g_pa
                assign pldSrc[i] = cellVal[i];
            end else if (i < 16) begin : g_pb
                assign pldSrc[i] = cfgBCellSel[i-8] ? cellVal[i] : cellVal[i-8];
            end else if (i < 24) begin : g_pc
                assign pldSrc[i] = cellVal[i-8];
            end else if (i == 24) begin : g_pd0
                assign pldSrc[i] = 1'b0;
            end else begin : g_pdx
                assign pldSrc[i] = ecsTerm[i-25];
            end
            if (i < 16) begin : g_ctl
                assign muxOut[i] = ctl_r[i] ? addrLat_r[i%8] :
                                   (cfgPinPld[i] ? pldSrc[i] : dout_r[i]);
            end else begin : g_noctl
                assign muxOut[i] = cfgPinPld[i] ? pldSrc[i] : dout_r[i];
            end
            assign oeNxt[i] = dir_r[i] | (ptOe[i] & cfgOeDef[i])
                            | (cfgPinPld[i] & ~cfgOeDef[i]);
        end
        for (i = 0; i < 20; i = i + 1) begin : g_in
            localparam PIN = (i < 16) ? i : ((i == 19) ? 23 : i + 2);
            assign inCellPin[i] = pinS2_r[PIN];
        end
        for (i = 0; i < 5; i = i + 1) begin : g_inen
            assign inEn[i] = cfgInAle[i] ? busAle : ptInEn[i];
        end
    endgenerate

    always @* begin
        rdMux = `PMIO_RD_UNMAPPED;
        if (busAddr <= `PMIO_OFS_DIN_D) begin
            rdMux = pinPad[busAddr[1:0]*8 +: 8];
        end else if (busAddr <= `PMIO_OFS_DOUT_D) begin
            rdMux = doutPad[busAddr[1:0]*8 +: 8];
        end else if (busAddr <= `PMIO_OFS_DIR_D) begin
            rdMux = dirPad[busAddr[1:0]*8 +: 8];
        end else begin
            case (busAddr)
                `PMIO_OFS_CTL_A:    rdMux = ctl_r[7:0];
                `PMIO_OFS_CTL_B:    rdMux = ctl_r[15:8];
                `PMIO_OFS_INCELL_A: rdMux = inPad[7:0];
                `PMIO_OFS_INCELL_B: rdMux = inPad[15:8];
                `PMIO_OFS_INCELL_C: rdMux = inPad[23:16];
                `PMIO_OFS_CELL_A:   rdMux = cellQ_r[7:0];
                `PMIO_OFS_CELL_B:   rdMux = cellQ_r[15:8];
                `PMIO_OFS_MASK_A:   rdMux = maskA_r;
                `PMIO_OFS_MASK_B:   rdMux = maskB_r;
                default:            rdMux = `PMIO_RD_UNMAPPED;
            endcase
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinS1_r      <= `PMIO_RST_PINS;
            pinS2_r      <= `PMIO_RST_PINS;
            clkPinPrev_r <= 1'b0;
            wrStb_r      <= 1'b0;
            wSel_r       <= 1'b0;
            wAddr_r      <= `PMIO_RST_REG8;
            wData_r      <= `PMIO_RST_REG8;
            addrLat_r    <= `PMIO_RST_REG8;
            busRdData    <= `PMIO_RST_REG8;
            pinOut_r     <= `PMIO_RST_PINS;
            pinOe_r      <= `PMIO_RST_PINS;
        end else begin
            pinS1_r      <= pinRaw;
            pinS2_r      <= pinS1_r;
            clkPinPrev_r <= pinS2_r[`PMIO_PIN_CLKIN];
            wrStb_r      <= busWrStb;
            if (busWrStb) begin
                wSel_r  <= ioSel;
                wAddr_r <= busAddr;
                wData_r <= busWrData;
            end
            if (busAle) begin
                addrLat_r <= busAddr;
            end
            // Only the addressed source reaches the data bus; idle reads return zero.
            busRdData <= (busRdStb & ioSel) ? rdMux : `PMIO_RD_UNMAPPED;
            pinOut_r  <= muxOut;
            pinOe_r   <= oeNxt;
        end
    end

    // Run-time registers; the modes fixed by programming arrive as cfg inputs instead.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_r  <= `PMIO_RST_PINS;
            dir_r   <= `PMIO_RST_PINS;
            ctl_r   <= {`PMIO_RST_REG8, `PMIO_RST_REG8};
            maskA_r <= `PMIO_RST_REG8;
            maskB_r <= `PMIO_RST_REG8;
        end else if (regWr) begin
            case (wAddr_r)
                `PMIO_OFS_DOUT_A: dout_r[7:0]   <= wData_r;
                `PMIO_OFS_DOUT_B: dout_r[15:8]  <= wData_r;
                `PMIO_OFS_DOUT_C: dout_r[23:16] <= wData_r;
                `PMIO_OFS_DOUT_D: dout_r[26:24] <= wData_r[2:0];
                `PMIO_OFS_DIR_A:  dir_r[7:0]    <= wData_r;
                `PMIO_OFS_DIR_B:  dir_r[15:8]   <= wData_r;
                `PMIO_OFS_DIR_C:  dir_r[23:16]  <= wData_r;
                `PMIO_OFS_DIR_D:  dir_r[26:24]  <= wData_r[2:0];
                `PMIO_OFS_CTL_A:  ctl_r[7:0]    <= wData_r;
                `PMIO_OFS_CTL_B:  ctl_r[15:8]   <= wData_r;
                `PMIO_OFS_MASK_A: maskA_r       <= wData_r;
                `PMIO_OFS_MASK_B: maskB_r       <= wData_r;
                default:          ctl_r         <= ctl_r;
            endcase
        end
    end

    integer k;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cellQ_r     <= `PMIO_RST_CELLS;
            ptClkPrev_r <= `PMIO_RST_CELLS;
            cellOut     <= `PMIO_RST_CELLS;
        end else begin
            ptClkPrev_r <= cellClkPt;
            cellOut     <= cellVal;
            for (k = 0; k < 16; k = k + 1) begin
                // A masked cell ignores the write and keeps running its own logic.
                if ((k < 8) ? (cellWrA & ~maskA_r[k]) : (cellWrB & ~maskB_r[k-8])) begin
                    cellQ_r[k] <= cellData[k%8];
                end else if (cellClear[k]) begin
                    cellQ_r[k] <= 1'b0;
                end else if (cellPreset[k]) begin
                    cellQ_r[k] <= 1'b1;
                end else if (cfgClkPin[k] ? clkPinRise : (cellClkPt[k] & ~ptClkPrev_r[k])) begin
                    cellQ_r[k] <= cellSum[k];
                end
            end
        end
    end


    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inEnPrev_r <= 5'h00;
            inCellBus  <= 20'h00000;
        end else begin
            inEnPrev_r <= inEn;
            for (k = 0; k < 20; k = k + 1) begin
                case (cfgInMode[2*k +: 2])
                    `PMIO_MODE_PASS:  inCellBus[k] <= inCellPin[k];
                    `PMIO_MODE_LATCH: if (inEn[k/4]) inCellBus[k] <= inCellPin[k];
                    `PMIO_MODE_REG:   if (inEn[k/4] & ~inEnPrev_r[k/4])
                                          inCellBus[k] <= inCellPin[k];
                    default:          inCellBus[k] <= inCellPin[k];
                endcase
            end
        end
    end
endmodule // pmio_ports

// ### rtl/pmio_consts.vh
// Register offsets, reset values and port geometry for the macrocell and I/O port block.
`ifndef PMIO_CONSTS_VH
`define PMIO_CONSTS_VH
`define PMIO_OFS_DIN_A    8'h00
`define PMIO_OFS_DIN_D    8'h03
`define PMIO_OFS_DOUT_A   8'h04
`define PMIO_OFS_DOUT_B   8'h05
`define PMIO_OFS_DOUT_C   8'h06
`define PMIO_OFS_DOUT_D   8'h07
`define PMIO_OFS_DIR_A    8'h08
`define PMIO_OFS_DIR_B    8'h09
`define PMIO_OFS_DIR_C    8'h0a
`define PMIO_OFS_DIR_D    8'h0b
`define PMIO_OFS_CTL_A    8'h0c
`define PMIO_OFS_CTL_B    8'h0d
`define PMIO_OFS_INCELL_A 8'h0e
`define PMIO_OFS_INCELL_B 8'h0f
`define PMIO_OFS_INCELL_C 8'h10
`define PMIO_OFS_CELL_A   8'h11
`define PMIO_OFS_CELL_B   8'h12
`define PMIO_OFS_MASK_A   8'h13
`define PMIO_OFS_MASK_B   8'h14
`define PMIO_RST_REG8     8'h00
`define PMIO_RST_PINS     27'h0000000
`define PMIO_RST_CELLS    16'h0000
`define PMIO_RD_UNMAPPED  8'h00
`define PMIO_NAT_A        3
`define PMIO_NAT_B        4
`define PMIO_CAP_A        8'h3f
`define PMIO_CAP_B_LO     8'h1f
`define PMIO_CAP_B_HI     8'h3f
`define PMIO_PIN_CLKIN    25
`define PMIO_MODE_PASS    2'h0
`define PMIO_MODE_LATCH   2'h1
`define PMIO_MODE_REG     2'h2
`endif

// ### dv/pmio_ports_props.sv
// Concurrent checks on register reads, pin enables and output cell loading.
`timescale 1ns/1ps
`include "pmio_consts.vh"
module pmio_ports_props (
    input wire        ref_clk,
    input wire        sys_rst,
    input wire        ioSel,
    input wire [7:0]  busAddr,
    input wire [7:0]  busWrData,
    input wire        busWrStb,
    input wire        busRdStb,
    input wire [7:0]  busRdData,
    input wire [15:0] cellPreset,
    input wire [15:0] cellClear,
    input wire [15:0] cellClkPt,
    input wire [26:0] ptOe,
    input wire        cfgLevelLoad,
    input wire [15:0] cfgCombo,
    input wire [15:0] cfgClkPin,
    input wire [26:0] cfgPinPld,
    input wire [26:0] cfgOeDef,
    input wire [2:0]  pdIn,
    input wire [7:0]  pbOe,
    input wire [7:0]  pcOe,
    input wire [15:0] cellOut
);
    reg        stbQ_r;
    reg        selQ_r;
    reg  [7:0] addrQ_r;
    reg  [7:0] dataQ_r;
    reg  [7:0] maskA_r;
    reg  [7:0] maskB_r;
    wire       wrTake = stbQ_r & ~busWrStb & selQ_r;
    wire [7:0] termB = ptOe[15:8] & cfgOeDef[15:8];
    wire [7:0] pldC = cfgPinPld[23:16] & ~cfgOeDef[23:16];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // The masks are shadowed here because the checker cannot read them back.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stbQ_r <= 1'b0;
            selQ_r <= 1'b0;
            addrQ_r <= 8'h00;
            dataQ_r <= 8'h00;
            maskA_r <= 8'h00;
            maskB_r <= 8'h00;
        end else begin
            stbQ_r <= busWrStb;
            selQ_r <= ioSel;
            addrQ_r <= busAddr;
            dataQ_r <= busWrData;
            if (wrTake && addrQ_r == `PMIO_OFS_MASK_A) maskA_r <= dataQ_r;
            if (wrTake && addrQ_r == `PMIO_OFS_MASK_B) maskB_r <= dataQ_r;
        end
    end
    a_rd_idle_zero: assert property (!(busRdStb && ioSel) |=> busRdData == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_rd: assert property (busRdStb && ioSel && busAddr > `PMIO_OFS_MASK_B
        |=> busRdData == 8'h00) else $error("unmapped read not zero");
    a_oe_term: assert property ((pbOe & $past(termB)) == $past(termB))
        else $error("enable term did not enable pin");
    a_oe_pld_out: assert property (1'b1 |=> (pcOe & $past(pldC)) == $past(pldC))
        else $error("logic output without enable term not driven");
    // The cell output lags its flop by one cycle, so causes are looked at one cycle back.
    a_cell_quiet: assert property ($past(cellPreset) == 16'h0000
        && $past(cellClear) == 16'h0000 && $past(cellClkPt) == 16'h0000
        && $past(cfgClkPin) == 16'h0000 && cfgCombo == 16'h0000 && $past(cfgCombo) == 16'h0000
        && !$past(busWrStb) && !$past(busWrStb, 2) |=> $stable(cellOut))
        else $error("output cell changed without cause");
    a_cell_edge: assert property (wrTake && addrQ_r == `PMIO_OFS_CELL_A && !cfgLevelLoad
        |=> ##1 ((cellOut[7:0] ^ $past(dataQ_r, 2)) & ~$past(maskA_r, 2)) == 8'h00)
        else $error("edge load of group A wrong");
    a_mask_keep: assert property (wrTake && addrQ_r == `PMIO_OFS_CELL_A && !cfgLevelLoad
        && cellClear[7:0] == 8'h00 && cellPreset[7:0] == 8'h00 && cellClkPt[7:0] == 8'h00
        && cfgCombo[7:0] == 8'h00 && cfgClkPin[7:0] == 8'h00
        |=> ##1 ((cellOut[7:0] ^ $past(cellOut[7:0])) & $past(maskA_r, 2)) == 8'h00)
        else $error("masked group A cell changed on write");
    a_cell_level: assert property (cfgLevelLoad && busWrStb && ioSel
        && busAddr == `PMIO_OFS_CELL_B
        |=> ##1 ((cellOut[15:8] ^ $past(busWrData, 2)) & ~$past(maskB_r, 2)) == 8'h00)
        else $error("level load of group B wrong");
    a_pin_sync: assert property (busRdStb && ioSel && busAddr == `PMIO_OFS_DIN_D
        && !$past(sys_rst, 3) && $past(pdIn, 2) == pdIn && $past(pdIn) == pdIn
        |=> busRdData == {5'h00, $past(pdIn)}) else $error("port D pin read wrong");
    c_edge_load: cover property (wrTake && addrQ_r == `PMIO_OFS_CELL_A);
    c_level_load: cover property (cfgLevelLoad && busWrStb && ioSel);
    c_unmapped: cover property (busRdStb && ioSel && busAddr > `PMIO_OFS_MASK_B);
endmodule // pmio_ports_props
bind pmio_ports pmio_ports_props u_props (.ref_clk, .sys_rst, .ioSel, .busAddr, .busWrData,
    .busWrStb, .busRdStb, .busRdData, .cellPreset, .cellClear, .cellClkPt, .ptOe, .cfgLevelLoad,
    .cfgCombo, .cfgClkPin, .cfgPinPld, .cfgOeDef, .pdIn, .pbOe, .pcOe, .cellOut);

// ### dv/pmio_pin_model.sv
// Board around ports A-D: a pin follows the block while it drives, else the board's level.
`timescale 1ns/1ps
module pmio_pin_model (
    input  wire [7:0] paOut,
    input  wire [7:0] paOe,
    input  wire [7:0] pbOut,
    input  wire [7:0] pbOe,
    input  wire [7:0] pcOut,
    input  wire [7:0] pcOe,
    input  wire [7:0] extA,
    input  wire [7:0] extB,
    input  wire [7:0] extC,
    input  wire [2:0] pdOut,
    input  wire [2:0] pdOe,
    input  wire [2:0] extD,
    output wire [7:0] paIn,
    output wire [7:0] pbIn,
    output wire [7:0] pcIn,
    output wire [2:0] pdIn
);
    assign paIn = (paOut & paOe) | (extA & ~paOe);
    assign pbIn = (pbOut & pbOe) | (extB & ~pbOe);
    assign pcIn = (pcOut & pcOe) | (extC & ~pcOe);
    assign pdIn = (pdOut & pdOe) | (extD & ~pdOe);
endmodule // pmio_pin_model

// ### dv/tb_pmio_ports.sv
// Register-level tests of the macrocell and I/O port block.
`timescale 1ns/1ps
`include "pmio_consts.vh"
module tb_pmio_ports;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, ioSel = 1'b0, busWrStb = 1'b0;
    logic        busRdStb = 1'b0, busAle = 1'b0, cfgLevelLoad = 1'b0;
    logic [7:0]  busAddr = 8'h00, busWrData = 8'h00, cfgBCellSel = 8'h00;
    logic [7:0]  extA = 8'h00, extB = 8'h3c, extC = 8'h00;
    logic [2:0]  extD = 3'h6;
    logic [1:0]  ecsTerm = 2'h0;
    logic [4:0]  ptInEn = 5'h00, cfgInAle = 5'h00;
    logic [15:0] cellPreset = 16'h0000, cellClear = 16'h0000, cellClkPt = 16'h0000;
    logic [15:0] cfgPol = 16'h0000, cfgCombo = 16'h0000, cfgClkPin = 16'h0000;
    logic [26:0] ptOe = 27'h0000000, cfgPinPld = 27'h0040000, cfgOeDef = 27'h0000100;
    logic [31:0] cfgBorrow = 32'h00000000;
    logic [39:0] cfgInMode = 40'h0000000000;
    logic [55:0] ptTerms = 56'h00000000000000;
    wire  [7:0]  busRdData, paOut, paOe, pbOut, pbOe, pcOut, pcOe, paIn, pbIn, pcIn;
    wire  [2:0]  pdOut, pdOe, pdIn;
    wire  [15:0] cellOut;
    wire  [19:0] inCellBus;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    pmio_ports uut (.ref_clk, .sys_rst, .ioSel, .busAddr, .busWrData, .busWrStb, .busRdStb,
        .busAle, .busRdData, .ptTerms, .cellPreset, .cellClear, .cellClkPt, .ptOe, .ptInEn,
        .ecsTerm, .cfgLevelLoad, .cfgBorrow, .cfgPol, .cfgCombo, .cfgClkPin, .cfgPinPld,
        .cfgBCellSel, .cfgOeDef, .cfgInMode, .cfgInAle, .paIn, .pbIn, .pcIn, .pdIn, .paOut,
        .paOe, .pbOut, .pbOe, .pcOut, .pcOe, .pdOut, .pdOe, .cellOut, .inCellBus);
    pmio_pin_model board (.paOut, .paOe, .pbOut, .pbOe, .pcOut, .pcOe, .extA, .extB, .extC,
        .pdOut, .pdOe, .extD, .paIn, .pbIn, .pcIn, .pdIn);
    always #5 ref_clk = ~ref_clk;
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // A run far beyond the hundred or so cycles of the tests means a hang.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize;
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Write data is held through the edge that takes it, one cycle after the strobe falls.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int hi);
        wait_cyc(1);
        ioSel = 1'b1;
        busAddr = a;
        busWrData = d;
        busWrStb = 1'b1;
        wait_cyc(hi);
        busWrStb = 1'b0;
        wait_cyc(1);
        ioSel = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        wait_cyc(1);
        ioSel = 1'b1;
        busAddr = a;
        busRdStb = 1'b1;
        wait_cyc(1);
        check(name, busRdData, exp);
        busRdStb = 1'b0;
        ioSel = 1'b0;
    endtask
    initial begin
        wait_cyc(12);
        sys_rst = 1'b0;
        rd(`PMIO_OFS_MASK_A, 8'h00, "maskA");
        rd(`PMIO_OFS_MASK_B, 8'h00, "maskB");
        rd(`PMIO_OFS_DIR_A, 8'h00, "dirA");
        rd(`PMIO_OFS_CTL_B, 8'h00, "ctlB");
        rd(8'h3f, 8'h00, "unmapped");
        rd(`PMIO_OFS_DIN_D, 8'h06, "pinD");
        check("pcOe2", pcOe[2], 1'b1);
        check("paOe", paOe, 8'h00);
        $display("test reset done");
        wr(`PMIO_OFS_DIR_A, 8'hff, 1);
        wr(`PMIO_OFS_DOUT_A, 8'h55, 1);
        wait_cyc(2);
        check("paOut", paOut, 8'h55);
        check("paOe", paOe, 8'hff);
        rd(`PMIO_OFS_DOUT_A, 8'h55, "doutA");
        rd(`PMIO_OFS_DIN_A, 8'h55, "pinA");
        wr(`PMIO_OFS_DIR_D, 8'hff, 1);
        rd(`PMIO_OFS_DIR_D, 8'h07, "dirD");
        wr(`PMIO_OFS_DOUT_D, 8'hfd, 1);
        wait_cyc(2);
        check("pdOe", pdOe, 8'h07);
        check("pdOut", pdOut, 8'h05);
        rd(`PMIO_OFS_DIN_D, 8'h05, "pinDOut");
        $display("test processor io done");
        wr(`PMIO_OFS_CTL_A, 8'hff, 1);
        busAddr = 8'ha5;
        busAle = 1'b1;
        wait_cyc(1);
        busAle = 1'b0;
        wait_cyc(2);
        check("paAddr", paOut, 8'ha5);
        wr(`PMIO_OFS_CTL_A, 8'h00, 1);
        wait_cyc(2);
        check("paBack", paOut, 8'h55);
        $display("test address out done");
        ptOe[9:8] = 2'h3;
        wait_cyc(2);
        check("pbOeOn", pbOe, 8'h01);
        ptOe[9:8] = 2'h0;
        wait_cyc(2);
        check("pbOeOff", pbOe, 8'h00);
        check("inCellB", inCellBus[15:8], 8'h3c);
        rd(`PMIO_OFS_INCELL_B, 8'h3c, "inCellRd");
        // Port B low nibble latches on the address strobe, high nibble registers on its term.
        cfgInMode[31:16] = 16'haa55;
        cfgInAle[2] = 1'b1;
        extB = 8'hc3;
        wait_cyc(4);
        check("inCellHeld", inCellBus[15:8], 8'h3c);
        busAle = 1'b1;
        wait_cyc(1);
        busAle = 1'b0;
        wait_cyc(1);
        check("inCellAle", inCellBus[15:8], 8'h33);
        ptInEn[3] = 1'b1;
        wait_cyc(2);
        ptInEn[3] = 1'b0;
        rd(`PMIO_OFS_INCELL_B, 8'hc3, "inCellTerm");
        $display("test enables and input cells done");
        wr(`PMIO_OFS_MASK_A, 8'h0f, 1);
        wr(`PMIO_OFS_CELL_A, 8'hff, 1);
        rd(`PMIO_OFS_CELL_A, 8'hf0, "cellA");
        wr(`PMIO_OFS_CELL_B, 8'h5a, 1);
        rd(`PMIO_OFS_CELL_B, 8'h5a, "cellB");
        cfgLevelLoad = 1'b1;
        wr(`PMIO_OFS_CELL_B, 8'ha5, 3);
        cfgLevelLoad = 1'b0;
        rd(`PMIO_OFS_CELL_B, 8'ha5, "cellLevel");
        check("cellOutB", cellOut[15:8], 8'ha5);
        check("pcOutCell", pcOut[2], 1'b1);
        cfgPinPld[15] = 1'b1;
        cfgBCellSel[7] = 1'b1;
        wait_cyc(2);
        check("pbOutCell", pbOut[7], 1'b1);
        check("pbOeCell", pbOe[7], 1'b1);
        cellPreset[9] = 1'b1;
        wait_cyc(1);
        cellPreset[9] = 1'b0;
        rd(`PMIO_OFS_CELL_B, 8'ha7, "cellPreset");
        // Cell 0 borrows cell 1's only live term, which then leaves cell 1.
        cfgCombo[1:0] = 2'h3;
        ptTerms[3] = 1'b1;
        cfgBorrow[0] = 1'b1;
        wait_cyc(2);
        check("cellLent", cellOut[1:0], 2'h1);
        cfgBorrow[0] = 1'b0;
        wait_cyc(2);
        check("cellOwn", cellOut[1:0], 2'h2);
        cfgCombo[1:0] = 2'h0;
        $display("test output cells done");
        summarize;
    end
endmodule // tb_pmio_ports
